// File: core/lcd_clk_pkg.sv
// Purpose: Types for the clock and mode block
// Assumes: Nothing
// Notes:   One-hot source modes
package lcd_clk_pkg;
    typedef enum logic [2:0] {
        SRC_INT  = 3'b001,
        SRC_SLOW = 3'b010,
        SRC_FAST = 3'b100
    } src_mode_type;

    typedef struct packed {
        logic ext_rate_range;
        logic clock_out_enable;
        logic src_ext;
    } osc_cfg_type;

    typedef struct packed {
        logic [1:0] mux_ratio;
        logic [1:0] bias_ratio;
    } drive_cfg_type;
endpackage

// File: core/lcd_clk_regs.svh
// Purpose: Command codes, reset values and timing counts
// Assumes: 125 MHz reference clock
// Notes:   Included by the clock and mode block
`ifndef LCD_CLK_REGS_SVH
`define LCD_CLK_REGS_SVH
// ---------------------------------------------
// Command byte layout
// ---------------------------------------------
`define OSC_CMD_TAG     5'b00011
`define MUX_CMD_TAG     6'b000000
`define BIAS_CMD_TAG    6'b000001
`define FRM_CMD_TAG     3'b001
`define EFR_BIT         2
`define COE_BIT         1
`define SRC_BIT         0
// ---------------------------------------------
// Reset values
// ---------------------------------------------
`define FD_RESET        5'h0e
`define FD_LAST         5'h16
`define MUX_RESET       2'h0
`define BIAS_RESET      2'h0
`define Q_RESET         7'h18
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define REF_CLK_HZ      125000000
`define OSC_FREQ_HZ     230000
`define OSC_DIV_CYC     (`REF_CLK_HZ / `OSC_FREQ_HZ)
`define FRAME_STEPS     6'h30
`endif

// File: core/lcd_frame_clock_and_mode_config.sv
// Purpose: Clock source, frame prescaler and drive mode commands
// Assumes: Command bytes arrive one per strobe on ref_clk_i
// Notes:   Internal oscillator is a tick derived from ref_clk_i
//
// What this block does
// RULE1: Source select 1 releases the clock pin as external clock input.
// RULE2: Range bit tells timing whether external clock is 9.6 or 230 kHz.
// RULE3: External slow clock: one frame per 48 input periods, no divider.
// RULE4: 230 kHz clock: frame period is 48 times q input periods.
// RULE5: Five-bit code picks q from table, 80 down to 16, default 24.
// RULE6: Frame command is 001 then the five-bit divider code.
// RULE7: Frame rate is a pure integer division of the clock.
// RULE8: Internal clock with output on drives divided clock on the pin.
// RULE9: Internal clock with output off leaves the pin floating.
// RULE10: During reset the pin is floating.
// RULE11: Power-down with output off floats pin, external clock optional.
// RULE12: External clock keeps running while display is on.
// RULE13: Multiplex command 000000 plus ratio: 8, 8, 6, 4 backplanes.
// RULE14: Bias command 000001 plus field: quarter, quarter, half, third.
// RULE15: Data transfer steps follow generated frame timing.
// RULE16: Divider code sets frame rate about 60 to 300 Hz.
// RULE17: Oscillator command 00011 then range, output enable, source.
// RULE18: Power-down with internal clock and output on drives pin high.
// RULE19: Unused divider code leaves stored code unchanged.
// RULE20: Divider and source changes apply at next frame boundary.
`timescale 1ns/10ps
`include "lcd_clk_regs.svh"
module lcd_frame_clock_and_mode_config (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // Command port
    input  wire logic       cmd_valid_i,
    input  wire logic [7:0] cmd_byte_i,
    input  wire logic       power_down_bit_i,
    // Clock pin
    input  wire logic       clock_io_pin_i,
    output logic            clock_io_pin_o,
    output logic            clock_io_pin_oe_o,
    // Timing and mode
    output logic            frame_pulse_o,
    output logic            data_step_o,
    output logic [3:0]      backplanes_o,
    output logic [1:0]      bias_ratio_o
);
    // ---------------------------------------------
    // Divider table
    // ---------------------------------------------
    function automatic logic [6:0] q_of(input logic [4:0] c);
        case (c)
            5'h00: q_of = 7'h50;
            5'h01: q_of = 7'h44;
            5'h02: q_of = 7'h3c;
            5'h03: q_of = 7'h35;
            5'h04: q_of = 7'h30;
            5'h05: q_of = 7'h2c;
            5'h06: q_of = 7'h28;
            5'h07: q_of = 7'h25;
            5'h08: q_of = 7'h22;
            5'h09: q_of = 7'h20;
            5'h0a: q_of = 7'h1e;
            5'h0b: q_of = 7'h1c;
            5'h0c: q_of = 7'h1b;
            5'h0d: q_of = 7'h19;
            5'h0e: q_of = 7'h18;
            5'h0f: q_of = 7'h17;
            5'h10: q_of = 7'h16;
            5'h11: q_of = 7'h15;
            5'h12: q_of = 7'h14;
            5'h13: q_of = 7'h13;
            5'h14: q_of = 7'h12;
            5'h15: q_of = 7'h11;
            default: q_of = 7'h10;
        endcase
    endfunction

    localparam logic [9:0] OSC_DIV = 10'(`OSC_DIV_CYC);

    lcd_clk_pkg::osc_cfg_type   osc_reg;
    lcd_clk_pkg::drive_cfg_type drv_reg;
    lcd_clk_pkg::src_mode_type  mode_reg;
    lcd_clk_pkg::src_mode_type  mode_next;
    logic [4:0] fd_reg;
    logic [6:0] q_reg;
    logic [9:0] osc_cnt_reg;
    logic       osc_tick_reg;
    logic       s1_reg;
    logic       s2_reg;
    logic       s3_reg;
    logic       ext_lvl_reg;
    logic       ext_edge_reg;
    logic [6:0] pre_cnt_reg;
    logic [5:0] frm_cnt_reg;
    logic       tick;
    logic       inter_tick;
    logic       frame_end;
    logic       frame_idle_reg;
    logic       cfg_load;

    // ---------------------------------------------
    // Command decode
    // ---------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            osc_reg <= '0;
            drv_reg <= {`MUX_RESET, `BIAS_RESET};
            fd_reg  <= `FD_RESET;
        end else if (cmd_valid_i) begin
            if (cmd_byte_i[7:3] == `OSC_CMD_TAG) begin // RULE17
                osc_reg <= {cmd_byte_i[`EFR_BIT], cmd_byte_i[`COE_BIT],
                            cmd_byte_i[`SRC_BIT]};
            end
            if (cmd_byte_i[7:2] == `MUX_CMD_TAG) begin // RULE13
                drv_reg.mux_ratio <= cmd_byte_i[1:0];
            end
            if (cmd_byte_i[7:2] == `BIAS_CMD_TAG) begin // RULE14
                drv_reg.bias_ratio <= cmd_byte_i[1:0];
            end
            if (cmd_byte_i[7:5] == `FRM_CMD_TAG
                && cmd_byte_i[4:0] <= `FD_LAST) begin // RULE6 RULE19
                fd_reg <= cmd_byte_i[4:0];
            end
        end
    end

    // ---------------------------------------------
    // Mode outputs
    // ---------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            backplanes_o <= 4'h8;
            bias_ratio_o <= `BIAS_RESET;
        end else begin
            case (drv_reg.mux_ratio) // RULE13
                2'h2:    backplanes_o <= 4'h6;
                2'h3:    backplanes_o <= 4'h4;
                default: backplanes_o <= 4'h8;
            endcase
            bias_ratio_o <= drv_reg.bias_ratio; // RULE14
        end
    end

    // ---------------------------------------------
    // Clock sources
    // ---------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || power_down_bit_i || mode_reg != lcd_clk_pkg::SRC_INT) begin
            osc_cnt_reg  <= '0; // RULE18
            osc_tick_reg <= 1'b0;
        end else begin
            osc_tick_reg <= (osc_cnt_reg == OSC_DIV - 10'h1);
            osc_cnt_reg  <= (osc_cnt_reg == OSC_DIV - 10'h1) ? '0
                          : osc_cnt_reg + 10'h1;
        end
    end

    // External pin filter, edge once stages two and three agree
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s1_reg       <= 1'b0;
            s2_reg       <= 1'b0;
            s3_reg       <= 1'b0;
            ext_lvl_reg  <= 1'b0;
            ext_edge_reg <= 1'b0;
        end else begin
            s1_reg       <= clock_io_pin_i;
            s2_reg       <= s1_reg;
            s3_reg       <= s2_reg;
            if (s2_reg == s3_reg) begin
                ext_lvl_reg <= s3_reg;
            end
            ext_edge_reg <= (s2_reg == s3_reg) && s3_reg && !ext_lvl_reg;
        end
    end

    always_comb begin
        if (power_down_bit_i) begin
            tick = 1'b0; // RULE11
        end else if (mode_reg == lcd_clk_pkg::SRC_INT) begin
            tick = osc_tick_reg;
        end else begin
            tick = ext_edge_reg;
        end
        if (mode_reg == lcd_clk_pkg::SRC_SLOW) begin
            inter_tick = tick; // RULE3
        end else begin
            inter_tick = tick && (pre_cnt_reg == q_reg - 7'h1); // RULE4 RULE7
        end
        frame_end = inter_tick && (frm_cnt_reg == `FRAME_STEPS - 6'h1);
        cfg_load  = frame_end || (frame_idle_reg && !tick); // RULE20
        if (!osc_reg.src_ext) begin
            mode_next = lcd_clk_pkg::SRC_INT;
        end else if (osc_reg.ext_rate_range) begin
            mode_next = lcd_clk_pkg::SRC_FAST; // RULE2
        end else begin
            mode_next = lcd_clk_pkg::SRC_SLOW;
        end
    end

    // ---------------------------------------------
    // Prescaler and frame counter
    // ---------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mode_reg <= lcd_clk_pkg::SRC_INT;
            q_reg    <= `Q_RESET;
        end else if (cfg_load) begin
            mode_reg <= mode_next; // RULE20
            q_reg    <= q_of(fd_reg); // RULE5 RULE16
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || frame_end) begin
            pre_cnt_reg <= '0;
            frm_cnt_reg <= '0;
        end else if (tick) begin
            pre_cnt_reg <= inter_tick ? '0 : pre_cnt_reg + 7'h1; // RULE7
            if (inter_tick) begin
                frm_cnt_reg <= frm_cnt_reg + 6'h1;
            end
        end
    end

    // No tick counted yet in this frame, so config may still move
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || frame_end) begin
            frame_idle_reg <= 1'b1;
        end else if (tick) begin
            frame_idle_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            frame_pulse_o <= 1'b0;
            data_step_o   <= 1'b0;
        end else begin
            frame_pulse_o <= frame_end;
            data_step_o   <= inter_tick; // RULE15
        end
    end

    // ---------------------------------------------
    // Clock pin driver
    // ---------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            clock_io_pin_oe_o <= 1'b0; // RULE10
            clock_io_pin_o    <= 1'b0;
        end else begin
            clock_io_pin_oe_o <= !osc_reg.src_ext
                              && osc_reg.clock_out_enable; // RULE1 RULE9 RULE11
            if (power_down_bit_i) begin
                clock_io_pin_o <= 1'b1; // RULE18
            end else begin
                clock_io_pin_o <= (mode_reg == lcd_clk_pkg::SRC_INT)
                               && (pre_cnt_reg < (q_reg >> 1)); // RULE8
            end
        end
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    logic [5:0] step_seen;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || frame_pulse_o) begin
            step_seen <= '0;
        end else if (data_step_o) begin
            step_seen <= step_seen + 6'h1;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_reset_pin_float: assert property (@(posedge ref_clk_i) disable iff (1'b0)
        rst_i |=> !clock_io_pin_oe_o) else $error("pin driven after reset"); // RULE10
    a_ext_pin_release: assert property (osc_reg.src_ext |=> !clock_io_pin_oe_o)
        else $error("pin driven with external source"); // RULE1
    a_int_out_off: assert property (!osc_reg.src_ext && !osc_reg.clock_out_enable
        |=> !clock_io_pin_oe_o) else $error("pin driven with output off"); // RULE9
    a_pd_pin_high: assert property (power_down_bit_i && !osc_reg.src_ext
        && osc_reg.clock_out_enable |=> clock_io_pin_oe_o && clock_io_pin_o)
        else $error("pin not high in power-down"); // RULE18
    a_frame_steps: assert property (frame_pulse_o |-> step_seen == 6'h2f && data_step_o)
        else $error("frame not 48 steps"); // RULE4
    a_slow_no_div: assert property (mode_reg == lcd_clk_pkg::SRC_SLOW && tick
        |=> data_step_o) else $error("slow clock divided"); // RULE3
    a_bad_code_kept: assert property (cmd_valid_i && cmd_byte_i[7:5] == `FRM_CMD_TAG
        && cmd_byte_i[4:0] > `FD_LAST |=> $stable(fd_reg))
        else $error("unused code stored"); // RULE19
    a_code_stored: assert property (cmd_valid_i && cmd_byte_i[7:5] == `FRM_CMD_TAG
        && cmd_byte_i[4:0] <= `FD_LAST |=> fd_reg == $past(cmd_byte_i[4:0]))
        else $error("divider code not stored"); // RULE6
    a_mode_at_frame: assert property (!$stable(mode_reg) || !$stable(q_reg)
        |-> pre_cnt_reg == 7'h0 && frm_cnt_reg == 6'h0)
        else $error("change off frame boundary"); // RULE20
    a_q_range: assert property (q_reg >= 7'h10 && q_reg <= 7'h50)
        else $error("q out of table"); // RULE5

    c_int_frame: cover property (mode_reg == lcd_clk_pkg::SRC_INT && frame_pulse_o);
    c_to_ext: cover property (mode_reg == lcd_clk_pkg::SRC_INT
        ##1 mode_reg == lcd_clk_pkg::SRC_FAST);
    c_pd_drive: cover property (power_down_bit_i && clock_io_pin_oe_o);
endmodule

// File: verification/host_cmd_model.sv
// Purpose: Host side model sending command bytes and an external clock
// Assumes: One byte per strobe cycle, launched on the falling edge
// Notes:   Released clock line has no pull, so it toggles every cycle
`timescale 1ns/10ps
module host_cmd_model (
    // Clock
    input  wire logic       ref_clk_i,
    // Command port
    output logic            cmd_valid_o,
    output logic [7:0]      cmd_byte_o,
    // External clock
    input  wire logic       ext_run_i,
    output logic            ext_clk_o
);
    logic [3:0] ext_cnt;

    initial begin
        cmd_valid_o = 1'b0;
        cmd_byte_o  = 8'h00;
        ext_clk_o   = 1'b0;
        ext_cnt     = 4'h0;
    end

    // ---------------------------------------------
    // Command bytes
    // ---------------------------------------------
    task automatic send(input logic [7:0] b);
        @(negedge ref_clk_i);
        cmd_valid_o = 1'b1;
        cmd_byte_o  = b;
        @(negedge ref_clk_i);
        cmd_valid_o = 1'b0;
    endtask

    // ---------------------------------------------
    // External clock, 8 cycles per level
    // ---------------------------------------------
    always @(negedge ref_clk_i) begin
        ext_cnt <= ext_cnt + 4'h1;
        if (ext_run_i) begin
            ext_clk_o <= ext_cnt[3];
        end else begin
            ext_clk_o <= ~ext_clk_o;
        end
    end
endmodule

// File: verification/test_lcd_frame_clock_and_mode_config.sv
// Purpose: Self-checking bench for the clock and mode block
// Assumes: Inputs change on the falling edge of ref_clk
// Notes:   Internal frames too long to finish; external frames run whole
`timescale 1ns/10ps
`include "lcd_clk_regs.svh"
module test_lcd_frame_clock_and_mode_config;
    logic       ref_clk = 1'b0;
    logic       rst     = 1'b1;
    logic       pd      = 1'b0;
    logic       ext_run = 1'b0;
    logic       cmd_valid;
    logic [7:0] cmd_byte;
    logic       ext_clk;
    logic       pin_in;
    logic       pin_out;
    logic       pin_oe;
    logic       frame_pulse;
    logic       data_step;
    logic [3:0] backplanes;
    logic [1:0] bias;
    int         fails   = 0;
    int         n_tests = 0;

    // External clock period of the host model, q of the last divider code
    localparam int EXT_PER = 16;
    localparam int Q_LAST  = 16;

    always #4 ref_clk = ~ref_clk;
    assign pin_in = pin_oe ? pin_out : ext_clk;

    host_cmd_model i_host_cmd_model (
        .ref_clk_i   (ref_clk),
        .cmd_valid_o (cmd_valid),
        .cmd_byte_o  (cmd_byte),
        .ext_run_i   (ext_run),
        .ext_clk_o   (ext_clk)
    );

    lcd_frame_clock_and_mode_config i_lcd_frame_clock_and_mode_config (
        .ref_clk_i         (ref_clk),
        .rst_i             (rst),
        .cmd_valid_i       (cmd_valid),
        .cmd_byte_i        (cmd_byte),
        .power_down_bit_i  (pd),
        .clock_io_pin_i    (pin_in),
        .clock_io_pin_o    (pin_out),
        .clock_io_pin_oe_o (pin_oe),
        .frame_pulse_o     (frame_pulse),
        .data_step_o       (data_step),
        .backplanes_o      (backplanes),
        .bias_ratio_o      (bias)
    );

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] b);
        i_host_cmd_model.send(b);
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic step_gap(output int n);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (data_step !== 1'b1 && n < 20000);
        chk(data_step, 1'b1);
    endtask

    task automatic close_out;
        if (fails == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic t_reset;
        repeat (10) @(negedge ref_clk);
        chk(pin_oe, 1'b0);
        chk(backplanes, 4'h8);
        chk(bias, `BIAS_RESET);
        rst = 1'b0;
        @(negedge ref_clk);
        chk(pin_oe, 1'b0);
    endtask

    task automatic t_modes;
        logic [3:0] bp_tbl [4] = '{4'h8, 4'h8, 4'h6, 4'h4};
        for (int m = 0; m < 4; m++) begin
            cmd({`MUX_CMD_TAG, m[1:0]});
            chk(backplanes, bp_tbl[m]);
            cmd({`BIAS_CMD_TAG, m[1:0]});
            chk(bias, m[1:0]);
        end
        cmd(8'hc3);
        chk({backplanes, bias}, {4'h4, 2'h3});
    endtask

    task automatic t_pin;
        cmd({`OSC_CMD_TAG, 3'b010});
        chk(pin_oe, 1'b1);
        pd = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk({pin_oe, pin_out}, 2'b11);
        pd = 1'b0;
        cmd({`OSC_CMD_TAG, 3'b000});
        chk(pin_oe, 1'b0);
        pd = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(pin_oe, 1'b0);
        pd = 1'b0;
    endtask

    task automatic t_ext;
        int n;
        int steps;
        ext_run = 1'b1;
        cmd({`FRM_CMD_TAG, `FD_LAST});
        cmd({`OSC_CMD_TAG, 3'b111});
        chk(pin_oe, 1'b0);
        step_gap(n);
        step_gap(n);
        chk(n, Q_LAST * EXT_PER);
        cmd({`OSC_CMD_TAG, 3'b001});
        step_gap(n);
        steps = 0;
        do begin
            step_gap(n);
            chk(n, Q_LAST * EXT_PER);
            steps++;
        end while (frame_pulse !== 1'b1 && steps < 60);
        steps = 0;
        do begin
            step_gap(n);
            chk(n, EXT_PER);
            steps++;
        end while (frame_pulse !== 1'b1 && steps < 60);
        chk(steps, `FRAME_STEPS);
    endtask

    task automatic t_period;
        int n = 0;
        int hi = 0;
        rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(pin_oe, 1'b0);
        rst = 1'b0;
        ext_run = 1'b0;
        @(negedge ref_clk);
        chk(backplanes, 4'h8);
        cmd({`FRM_CMD_TAG, 5'h17});
        cmd({`OSC_CMD_TAG, 3'b010});
        chk(pin_oe, 1'b1);
        step_gap(n);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
            hi += (pin_out === 1'b1);
            chk(frame_pulse, 1'b0);
        end while (data_step !== 1'b1 && n < 20000);
        chk(n, `Q_RESET * `OSC_DIV_CYC);
        chk(hi, (`Q_RESET / 2) * `OSC_DIV_CYC);
    endtask

    task automatic t_freeze;
        int steps = 0;
        pd = 1'b1;
        repeat (14000) begin
            @(negedge ref_clk);
            steps += (data_step === 1'b1);
        end
        chk(steps, 0);
        pd = 1'b0;
    endtask

    // ---------------------------------------------
    // Main sequence and watchdog
    // ---------------------------------------------
    initial begin
        t_reset();
        t_modes();
        t_pin();
        t_ext();
        t_period();
        t_freeze();
        close_out();
    end

    initial begin
        repeat (80000) @(posedge ref_clk);
        fails++;
        close_out();
    end
endmodule
